/* include/wsd_pkg.sv */
// Package with the register map, field positions and carriers of the wake and serial direction bank.
package wsd_pkg;

    // Register offsets on the runtime register port.
    localparam logic [7:0] OFF_WAKE_ENABLE_SIX   = 8'h0B;
    localparam logic [7:0] OFF_WAKE_STATUS_SEVEN = 8'h0C;
    localparam logic [7:0] OFF_WAKE_ENABLE_SEVEN = 8'h10;
    localparam logic [7:0] OFF_SERIAL_DIR_OPT    = 8'h12;
    localparam logic [7:0] OFF_RSVD_AFTER_OPT    = 8'h13;
    localparam logic [7:0] OFF_WAKE_STATUS       = 8'h20;
    localparam logic [7:0] OFF_WAKE_IRQ_MASK     = 8'h21;
    localparam logic [7:0] OFF_WAKE_CONTROL      = 8'h22;

    // Reset values.
    localparam logic [7:0] RST_WAKE_ENABLE_SIX   = 8'h00;
    localparam logic [7:0] RST_WAKE_ENABLE_SEVEN = 8'h00;
    localparam logic [7:0] RST_SERIAL_DIR_OPT    = 8'h44;
    localparam logic [7:0] RST_RSVD_AFTER_OPT    = 8'h44;
    localparam logic [7:0] RST_WAKE_STATUS       = 8'h00;
    localparam logic [7:0] RST_WAKE_IRQ_MASK     = 8'h00;
    localparam logic       RST_GLOBAL_WAKE_EN    = 1'b0;

    // Wake source positions in the enable, status and mask registers.
    localparam int BIT_BATTERY_LOW_SOURCE      = 0;
    localparam int BIT_GENERAL_INPUT_SIX_ZERO  = 2;
    localparam int BIT_GENERAL_INPUT_SIX_ONE   = 3;
    localparam int BIT_POWER_BUTTON_WAKE_EN    = 6;
    localparam int BIT_POWER_FAIL_RECOVERY_EN  = 7;
    localparam logic [7:0] WAKE_SOURCE_MASK    = 8'hCD;

    // Global wake enable position in the control register.
    localparam int BIT_GLOBAL_WAKE_ENABLE      = 0;

    // Serial direction option fields; port n uses base n times the stride.
    localparam int OPT_PORT_STRIDE             = 4;
    localparam int OPT_AUTO_DIRECTION_CONTROL  = 0;
    localparam int OPT_LINE_SELECT             = 1;
    localparam int OPT_POLARITY                = 2;
    localparam logic [7:0] SERIAL_OPT_MASK     = 8'h77;

    // Register port request carrier.
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } wsd_bus_req_t;

    // Modem control lines of one serial port, both active low.
    typedef struct packed {
        logic request_to_send_line_n;
        logic terminal_ready_line_n;
    } wsd_modem_lines_t;

endpackage

/* design/wsd_regs.sv */
// Wake enable registers and serial automatic direction control registers with a wake interrupt.
`timescale 1ns/1ps

// Function
// - Drive wake request low when source enabled, event pending and global enable set.
// - A disabled source still sets its status bit but never drives wake request.
// - Enable six bits: 0 battery low, 2-3 general inputs, 6 button, 7 recovery.
// - Enable six bits 0-6 clear only on standby reset; other resets leave them alone.
// - Recovery enable bit 7 lives on battery power, reset only by battery reset.
// - Enable seven is all reserved and resets to zero on battery reset.
// - Option bit 0 and bit 4 switch automatic direction control per port.
// - Line select 1 picks request-to-send, 0 picks terminal-ready, bits 1 and 5.
// - Polarity bits 2 and 6: 0 drives low when enabled, 1 drives high.
// - Global enable gates all sources at wake request but not at the interrupt; status records events regardless of enables.
module wsd_regs #(
    parameter int NUM_PORTS = 2
) (
    input  wire logic                                REF_CLK,
    input  wire logic                                RST_N,
    input  wire logic                                BAT_RST_N,
    input  wire wsd_pkg::wsd_bus_req_t               BUS_REQ,
    output logic [7:0]                               BUS_RDATA,
    input  wire logic [7:0]                          WAKE_EVENT,
    output logic                                     WAKE_REQUEST_OUT_N,
    output logic                                     IRQ,
    input  wire logic [NUM_PORTS-1:0]                TX_BUSY,
    input  wire wsd_pkg::wsd_modem_lines_t [NUM_PORTS-1:0] MODEM_IN,
    output wsd_pkg::wsd_modem_lines_t [NUM_PORTS-1:0]      MODEM_OUT
);

    logic [7:0] enable_six_q;
    logic       recovery_enable_q;
    logic [7:0] enable_seven_q;
    logic [7:0] serial_opt_q;
    logic [7:0] rsvd_after_q;
    logic [7:0] status_q;
    logic [7:0] status_d;
    logic [7:0] irq_mask_q;
    logic       global_wake_enable_q;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic       wake_request_n_q;
    logic       wake_request_n_d;
    logic [7:0] enable_six_view;
    logic       wr_hit_en6;
    logic       wr_hit_en7;
    logic       wr_hit_opt;
    logic       wr_hit_rsvd;
    logic       wr_hit_mask;
    logic       wr_hit_ctrl;
    logic       rd_hit_status;

    // Address decode of single-cycle write and read strobes.
    assign wr_hit_en6    = BUS_REQ.wr && (BUS_REQ.addr == wsd_pkg::OFF_WAKE_ENABLE_SIX);
    assign wr_hit_en7    = BUS_REQ.wr && (BUS_REQ.addr == wsd_pkg::OFF_WAKE_ENABLE_SEVEN);
    assign wr_hit_opt    = BUS_REQ.wr && (BUS_REQ.addr == wsd_pkg::OFF_SERIAL_DIR_OPT);
    assign wr_hit_rsvd   = BUS_REQ.wr && (BUS_REQ.addr == wsd_pkg::OFF_RSVD_AFTER_OPT);
    assign wr_hit_mask   = BUS_REQ.wr && (BUS_REQ.addr == wsd_pkg::OFF_WAKE_IRQ_MASK);
    assign wr_hit_ctrl   = BUS_REQ.wr && (BUS_REQ.addr == wsd_pkg::OFF_WAKE_CONTROL);
    assign rd_hit_status = BUS_REQ.rd && (BUS_REQ.addr == wsd_pkg::OFF_WAKE_STATUS);

    // Standby-domain part of wake enable six; only the standby reset clears it,
    // so main-power, software and host bus resets never reach this flop.
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            enable_six_q <= wsd_pkg::RST_WAKE_ENABLE_SIX;
        end else if (wr_hit_en6) begin
            enable_six_q <= BUS_REQ.wdata & wsd_pkg::WAKE_SOURCE_MASK;
        end
    end

    // Recovery enable sits in the battery domain and survives a standby reset.
    always_ff @(posedge REF_CLK) begin
        if (!BAT_RST_N) begin
            recovery_enable_q <= wsd_pkg::RST_WAKE_ENABLE_SIX[wsd_pkg::BIT_POWER_FAIL_RECOVERY_EN];
        end else if (wr_hit_en6) begin
            recovery_enable_q <= BUS_REQ.wdata[wsd_pkg::BIT_POWER_FAIL_RECOVERY_EN];
        end
    end

    // Reserved wake enable seven keeps its written value, cleared by battery reset only.
    always_ff @(posedge REF_CLK) begin
        if (!BAT_RST_N) begin
            enable_seven_q <= wsd_pkg::RST_WAKE_ENABLE_SEVEN;
        end else if (wr_hit_en7) begin
            enable_seven_q <= BUS_REQ.wdata;
        end
    end

    // Merge the two power domains into the register view; reserved bits read zero.
    always_comb begin
        enable_six_view = enable_six_q & wsd_pkg::WAKE_SOURCE_MASK;
        enable_six_view[wsd_pkg::BIT_POWER_FAIL_RECOVERY_EN] = recovery_enable_q;
    end

    // Serial direction options; reserved bits 3 and 7 are not stored.
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            serial_opt_q <= wsd_pkg::RST_SERIAL_DIR_OPT;
        end else if (wr_hit_opt) begin
            serial_opt_q <= BUS_REQ.wdata & wsd_pkg::SERIAL_OPT_MASK;
        end
    end

    // Reserved register after the options keeps whatever software writes.
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            rsvd_after_q <= wsd_pkg::RST_RSVD_AFTER_OPT;
        end else if (wr_hit_rsvd) begin
            rsvd_after_q <= BUS_REQ.wdata;
        end
    end

    // Interrupt mask and global wake enable.
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            irq_mask_q           <= wsd_pkg::RST_WAKE_IRQ_MASK;
            global_wake_enable_q <= wsd_pkg::RST_GLOBAL_WAKE_EN;
        end else begin
            if (wr_hit_mask) begin
                irq_mask_q <= BUS_REQ.wdata & wsd_pkg::WAKE_SOURCE_MASK;
            end
            if (wr_hit_ctrl) begin
                global_wake_enable_q <= BUS_REQ.wdata[wsd_pkg::BIT_GLOBAL_WAKE_ENABLE];
            end
        end
    end

    // Sticky wake status: events set bits whatever the enables, a read clears them,
    // and an event landing in the clearing cycle wins so it is never lost.
    always_comb begin
        status_d = status_q;
        if (rd_hit_status) begin
            status_d = 8'h00;
        end
        status_d = status_d | (WAKE_EVENT & wsd_pkg::WAKE_SOURCE_MASK);
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            status_q <= wsd_pkg::RST_WAKE_STATUS;
        end else begin
            status_q <= status_d;
        end
    end

    // Wake request follows the status gated per source and by the global enable;
    // registered so the pin never glitches while the status and enables settle.
    always_comb begin
        wake_request_n_d = 1'b1;
        if (global_wake_enable_q && |(status_q & enable_six_view)) begin
            wake_request_n_d = 1'b0;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            wake_request_n_q <= 1'b1;
        end else begin
            wake_request_n_q <= wake_request_n_d;
        end
    end

    assign WAKE_REQUEST_OUT_N = wake_request_n_q;

    // Level interrupt while any unmasked status bit stands.
    assign IRQ = |(status_q & irq_mask_q);

    // Read data mux; unmapped addresses and reserved status seven read zero.
    always_comb begin
        rdata_d = 8'h00;
        if (BUS_REQ.addr == wsd_pkg::OFF_WAKE_ENABLE_SIX) begin
            rdata_d = enable_six_view;
        end else if (BUS_REQ.addr == wsd_pkg::OFF_WAKE_STATUS_SEVEN) begin
            rdata_d = 8'h00;
        end else if (BUS_REQ.addr == wsd_pkg::OFF_WAKE_ENABLE_SEVEN) begin
            rdata_d = enable_seven_q;
        end else if (BUS_REQ.addr == wsd_pkg::OFF_SERIAL_DIR_OPT) begin
            rdata_d = serial_opt_q;
        end else if (BUS_REQ.addr == wsd_pkg::OFF_RSVD_AFTER_OPT) begin
            rdata_d = rsvd_after_q;
        end else if (BUS_REQ.addr == wsd_pkg::OFF_WAKE_STATUS) begin
            rdata_d = status_q;
        end else if (BUS_REQ.addr == wsd_pkg::OFF_WAKE_IRQ_MASK) begin
            rdata_d = irq_mask_q;
        end else if (BUS_REQ.addr == wsd_pkg::OFF_WAKE_CONTROL) begin
            rdata_d = {7'h00, global_wake_enable_q};
        end
    end

    // Read data stands only in the cycle after the read strobe, zero otherwise.
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            rdata_q <= 8'h00;
        end else if (BUS_REQ.rd) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign BUS_RDATA = rdata_q;

    // Per-port direction control. The transmitter reports busy from its first
    // start bit until the last stop bit has shifted out, so the line holds the
    // enabled level for the whole frame train; unselected lines pass through.
    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
        localparam int BASE = p * wsd_pkg::OPT_PORT_STRIDE;
        logic auto_on;
        logic sel_rts;
        logic drive_high;
        logic dir_level;
        wsd_pkg::wsd_modem_lines_t lines_d;
        wsd_pkg::wsd_modem_lines_t lines_q;

        assign auto_on    = serial_opt_q[BASE + wsd_pkg::OPT_AUTO_DIRECTION_CONTROL];
        assign sel_rts    = serial_opt_q[BASE + wsd_pkg::OPT_LINE_SELECT];
        assign drive_high = serial_opt_q[BASE + wsd_pkg::OPT_POLARITY];
        // Enabled level while sending, the opposite level while idle.
        assign dir_level  = TX_BUSY[p] ? drive_high : !drive_high;

        always_comb begin
            lines_d = MODEM_IN[p];
            if (auto_on) begin
                if (sel_rts) begin
                    lines_d.request_to_send_line_n = dir_level;
                end else begin
                    lines_d.terminal_ready_line_n = dir_level;
                end
            end
        end

        // Modem lines idle high (inactive) through reset.
        always_ff @(posedge REF_CLK) begin
            if (!RST_N) begin
                lines_q <= '{request_to_send_line_n: 1'b1, terminal_ready_line_n: 1'b1};
            end else begin
                lines_q <= lines_d;
            end
        end

        assign MODEM_OUT[p] = lines_q;
    end

endmodule

/* test/wsd_regs_checker.sv */
// Checker with the port-level properties of the wake and serial direction bank.
`timescale 1ns/1ps
module wsd_regs_checker #(
    parameter int NUM_PORTS = 2
) (
    input wire logic                                       REF_CLK,
    input wire logic                                       RST_N,
    input wire logic                                       BAT_RST_N,
    input wire wsd_pkg::wsd_bus_req_t                      BUS_REQ,
    input wire logic [7:0]                                 BUS_RDATA,
    input wire logic [7:0]                                 WAKE_EVENT,
    input wire logic                                       WAKE_REQUEST_OUT_N,
    input wire logic                                       IRQ,
    input wire logic [NUM_PORTS-1:0]                       TX_BUSY,
    input wire wsd_pkg::wsd_modem_lines_t [NUM_PORTS-1:0]  MODEM_IN,
    input wire wsd_pkg::wsd_modem_lines_t [NUM_PORTS-1:0]  MODEM_OUT
);
    logic [7:0] en_q;
    logic       gen_q;
    logic [7:0] opt_q;
    logic [7:0] m_q;

    // Shadow of enable six; bit 7 survives the standby reset, so it has its own clear.
    always_ff @(posedge REF_CLK) begin
        if (BUS_REQ.wr && BUS_REQ.addr == wsd_pkg::OFF_WAKE_ENABLE_SIX) en_q <= BUS_REQ.wdata;
        if (!RST_N) en_q[6:0] <= 7'h00;
        if (!BAT_RST_N) en_q[7] <= 1'b0;
    end

    // Shadows of the interrupt mask, the global enable and the serial options.
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            gen_q <= 1'b0;
            opt_q <= 8'h44;
            m_q   <= 8'h00;
        end else if (BUS_REQ.wr && BUS_REQ.addr == wsd_pkg::OFF_WAKE_IRQ_MASK) begin
            m_q <= BUS_REQ.wdata;
        end else if (BUS_REQ.wr && BUS_REQ.addr == wsd_pkg::OFF_WAKE_CONTROL) begin
            gen_q <= BUS_REQ.wdata[0];
        end else if (BUS_REQ.wr && BUS_REQ.addr == wsd_pkg::OFF_SERIAL_DIR_OPT) begin
            opt_q <= BUS_REQ.wdata;
        end
    end

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);

    a_wake_asserts:
    assert property (gen_q && |(WAKE_EVENT & en_q & wsd_pkg::WAKE_SOURCE_MASK) && !BUS_REQ.wr ##1 !BUS_REQ.wr
        |=> !WAKE_REQUEST_OUT_N) else $error("wake request missing after enabled event");
    a_wake_gated:
    assert property ((!gen_q || (en_q & wsd_pkg::WAKE_SOURCE_MASK) == 8'h00) |=> WAKE_REQUEST_OUT_N)
        else $error("wake request while gated off");
    a_enable_read:
    assert property (BUS_REQ.rd && BUS_REQ.addr == wsd_pkg::OFF_WAKE_ENABLE_SIX
        |=> BUS_RDATA == ($past(en_q) & wsd_pkg::WAKE_SOURCE_MASK)) else $error("enable six read wrong");
    a_options_read:
    assert property (BUS_REQ.rd && BUS_REQ.addr == wsd_pkg::OFF_SERIAL_DIR_OPT
        |=> BUS_RDATA == ($past(opt_q) & wsd_pkg::SERIAL_OPT_MASK)) else $error("options read wrong");
    a_auto_off_pass:
    assert property (!opt_q[0] |=> MODEM_OUT[0] == $past(MODEM_IN[0])) else $error("lines not passed with auto off");
    a_busy_level:
    assert property (opt_q[0] && opt_q[1] && TX_BUSY[0]
        |=> MODEM_OUT[0].request_to_send_line_n == $past(opt_q[2])) else $error("busy level wrong");
    a_idle_level:
    assert property (opt_q[0] && opt_q[1] && !TX_BUSY[0]
        |=> MODEM_OUT[0].request_to_send_line_n != $past(opt_q[2])) else $error("idle level wrong");
    a_other_pass:
    assert property (opt_q[0] && opt_q[1] |=> MODEM_OUT[0].terminal_ready_line_n
        == $past(MODEM_IN[0].terminal_ready_line_n)) else $error("unselected line not passed");
    a_second_port:
    assert property (opt_q[4] && !opt_q[5] && TX_BUSY[1]
        |=> MODEM_OUT[1].terminal_ready_line_n == $past(opt_q[6])) else $error("second port level wrong");
    a_irq_on_event:
    assert property (|(WAKE_EVENT & m_q & wsd_pkg::WAKE_SOURCE_MASK) && !BUS_REQ.wr |=> IRQ)
        else $error("interrupt missing after unmasked event");
endmodule

bind wsd_regs wsd_regs_checker #(.NUM_PORTS(NUM_PORTS)) u_chk (.REF_CLK(REF_CLK), .RST_N(RST_N),
    .BAT_RST_N(BAT_RST_N), .BUS_REQ(BUS_REQ), .BUS_RDATA(BUS_RDATA), .WAKE_EVENT(WAKE_EVENT),
    .WAKE_REQUEST_OUT_N(WAKE_REQUEST_OUT_N), .IRQ(IRQ), .TX_BUSY(TX_BUSY), .MODEM_IN(MODEM_IN), .MODEM_OUT(MODEM_OUT));

/* test/wsd_far_side.sv */
// Far side model: the wake sources and the transmitting serial cores.
`timescale 1ns/1ps
module wsd_far_side (
    input  wire logic                        ref_clk,
    output logic [7:0]                       wake_event,
    output logic [1:0]                       tx_busy,
    output wsd_pkg::wsd_modem_lines_t [1:0]  modem_in
);
    // Idle: no events, no frame, modem lines inactive high.
    initial begin
        wake_event = 8'h00;
        tx_busy = 2'b00;
        modem_in = '1;
    end

    // A wake source raises its event for one cycle only, the shortest case.
    task automatic wake_pulse(input logic [7:0] ev);
        @(posedge ref_clk);
        wake_event <= ev;
        @(posedge ref_clk);
        wake_event <= 8'h00;
    endtask

    // A serial core starts or ends a frame and sets its modem lines.
    task automatic drive(input int p, input logic busy, input logic [1:0] lines);
        @(posedge ref_clk);
        tx_busy[p] <= busy;
        modem_in[p] <= lines;
    endtask
endmodule

/* test/wsd_regs_tb_top.sv */
// Testbench top for the wake enable and serial direction register bank.
`timescale 1ns/1ps
module wsd_regs_tb_top;
    logic                             ref_clk, rst_n, bat_rst_n, wake_n, irq;
    logic [7:0]                       rdata, wake_event, b, o;
    logic [1:0]                       tx_busy, sm, li;
    wsd_pkg::wsd_bus_req_t            req;
    wsd_pkg::wsd_modem_lines_t [1:0]  modem_in, modem_out;
    int                               n_errors = 0, tests_run = 0;
    logic [7:0] ra [7] = '{8'h0B, 8'h0C, 8'h10, 8'h12, 8'h13, 8'h20, 8'h30};
    logic [7:0] rv [7] = '{8'h00, 8'h00, 8'h00, 8'h44, 8'h44, 8'h00, 8'h00};
    int         src [5] = '{0, 2, 3, 6, 7};

    // Free-running 200 MHz clock.
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    wsd_far_side u_far (.ref_clk(ref_clk), .wake_event(wake_event), .tx_busy(tx_busy), .modem_in(modem_in));
    wsd_regs #(.NUM_PORTS(2)) DUT (.REF_CLK(ref_clk), .RST_N(rst_n), .BAT_RST_N(bat_rst_n), .BUS_REQ(req),
        .BUS_RDATA(rdata), .WAKE_EVENT(wake_event), .WAKE_REQUEST_OUT_N(wake_n), .IRQ(irq), .TX_BUSY(tx_busy),
        .MODEM_IN(modem_in), .MODEM_OUT(modem_out));

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic give_verdict;
        if (n_errors == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // One-cycle write strobe; the strobe drops at the next edge.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        req.wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so it is sampled there.
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        req.rd <= 1'b0;
        #1;
        chk($sformatf("register %h", a), exp, rdata);
        // Read data must fall back to zero in the following cycle.
        @(posedge ref_clk);
        #1;
        chk("read data idle", 8'h00, rdata);
    endtask

    task automatic pulse_rst(input logic bat);
        @(posedge ref_clk);
        if (bat) bat_rst_n <= 1'b0;
        else rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        bat_rst_n <= 1'b1;
        rst_n <= 1'b1;
    endtask

    // Configure, fire one event, check outputs, then clear status by reading it.
    task automatic wake_case(input logic [7:0] en, input logic [7:0] ctl, input logic [7:0] mask, input logic [7:0] ev);
        wr(wsd_pkg::OFF_WAKE_ENABLE_SIX, en);
        wr(wsd_pkg::OFF_WAKE_CONTROL, ctl);
        wr(wsd_pkg::OFF_WAKE_IRQ_MASK, mask);
        u_far.wake_pulse(ev);
        repeat (3) @(posedge ref_clk);
        #1;
        chk("wake request", {7'h00, !(ctl[0] && |(en & ev & 8'hCD))}, {7'h00, wake_n});
        chk("interrupt", {7'h00, |(mask & ev & 8'hCD)}, {7'h00, irq});
        rd(wsd_pkg::OFF_WAKE_STATUS, ev & 8'hCD);
        chk("interrupt cleared", 8'h00, {7'h00, irq});
        repeat (2) @(posedge ref_clk);
        #1;
        chk("wake released", 8'h01, {7'h00, wake_n});
    endtask

    // Hang guard: a run that overstays its bound is a failure.
    initial begin
        #100us;
        n_errors++;
        give_verdict();
    end

    // Main sequence.
    initial begin
        rst_n = 1'b0;
        bat_rst_n = 1'b0;
        req = '0;
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        bat_rst_n <= 1'b1;
        for (int i = 0; i < 7; i++) rd(ra[i], rv[i]);
        wr(8'h0B, 8'hFF);
        rd(8'h0B, 8'hCD);
        wr(8'h12, 8'hFF);
        rd(8'h12, 8'h77);
        wr(8'h0C, 8'hFF);
        rd(8'h0C, 8'h00);
        wr(8'h0B, 8'hCD);
        wr(8'h10, 8'hA5);
        pulse_rst(1'b0);
        rd(8'h0B, 8'h80);
        rd(8'h10, 8'hA5);
        pulse_rst(1'b1);
        rd(8'h0B, 8'h00);
        rd(8'h10, 8'h00);
        wr(8'h21, 8'hFF);
        rd(8'h21, 8'hCD);
        wr(8'h22, 8'hFF);
        rd(8'h22, 8'h01);
        for (int i = 0; i < 5; i++) begin
            b = 8'h01 << src[i];
            wake_case(8'h00, 8'h01, b, b);
            wake_case(b, 8'h00, 8'h00, b);
            wake_case(b, 8'h01, b, b);
        end
        wake_case(8'hFF, 8'h01, 8'hFF, 8'h32);
        // An event landing in the status-read cycle must survive the clear.
        wr(8'h21, 8'h04);
        fork
            rd(8'h20, 8'h00);
            u_far.wake_pulse(8'h04);
        join
        chk("set wins", 8'h01, {7'h00, irq});
        rd(8'h20, 8'h04);
        // Every port, line choice and polarity: idle level, then busy level, unselected line passing.
        for (int k = 0; k < 8; k++) begin
            sm = k[1] ? 2'b10 : 2'b01;
            li = sm & {2{k[2]}};
            o = {5'h00, k[2], k[1], 1'b1} << (4 * k[0]);
            wr(8'h12, o);
            u_far.drive(k[0], 1'b0, li);
            repeat (3) @(posedge ref_clk);
            #1;
            chk("idle line", {6'h00, sm & {2{!k[2]}}}, {6'h00, modem_out[k[0]]});
            u_far.drive(k[0], 1'b1, ~li);
            repeat (5) @(posedge ref_clk);
            #1;
            chk("busy line", {6'h00, (sm & {2{k[2]}}) | ~sm}, {6'h00, modem_out[k[0]]});
            wr(8'h12, 8'h00);
            repeat (2) @(posedge ref_clk);
            #1;
            chk("auto off", {6'h00, ~li}, {6'h00, modem_out[k[0]]});
            u_far.drive(k[0], 1'b0, 2'b11);
        end
        give_verdict();
    end
endmodule
